// file: src/lcp_top.sv
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module lcp_top (
    input  wire logic        ref_clk_i,        // 10 MHz clock
    input  wire logic        reset_n_i,        // sync system reset
    input  wire logic        reg_reset_n_i,    // register reset pin
    input  wire logic        host_mode_i,      // 1 host, 0 hardware
    input  wire logic        shared_pin_i,     // shared pin level in
    output logic             shared_pin_o,     // shared pin drive
    output logic             shared_pin_oe_o,  // shared pin enable
    input  wire logic        jatt_cfg_lo_i,    // attenuator strap lo
    input  wire logic        jatt_cfg_hi_i,    // attenuator strap hi
    input  wire logic        jatt_path_sel_i,  // 1 tx path, 0 rx path
    input  wire logic        los_i,            // loss of signal level
    input  wire logic        rx_pos_i,         // recovered pos data
    input  wire logic        rx_neg_i,         // recovered neg data
    output logic             rx_pos_data_o,    // pos data out
    output logic             rx_neg_data_o,    // neg data out
    output logic [7:0]       jatt_depth_o,     // fifo depth, 0 = off
    output logic             jatt_en_o,        // attenuator enabled
    output logic             jatt_tx_path_o,   // attenuator in tx path
    output logic             irq_o,            // level interrupt
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb enable
    input  wire logic        pwrite,           // apb write
    input  wire logic [7:0]  paddr,            // apb address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic [31:0]      prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr           // apb error
);
    // pins from outside: two flops before use
    logic [6:0] pin_s;
    lcp_sync2 #(.W(7)) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .d_i       ({reg_reset_n_i, host_mode_i, shared_pin_i,
                     jatt_cfg_lo_i, jatt_cfg_hi_i, jatt_path_sel_i,
                     los_i}),
        .q_o       (pin_s)
    );
    logic rrst_n, host_s, mute_pin_s, ja_lo_s, ja_hi_s, path_s, los_s;
    assign {rrst_n, host_s, mute_pin_s, ja_lo_s, ja_hi_s, path_s,
            los_s} = pin_s;

    // pin or system reset restores every command register to its default (mask to all ones)
    logic regs_rst;
    assign regs_rst = !reset_n_i || !rrst_n;

    function automatic logic [7:0] depth_of(input logic lo,
                                            input logic hi);
        unique case ({lo, hi})
            2'b00: depth_of = lcp_pkg::DEPTH_16;
            2'b01: depth_of = lcp_pkg::DEPTH_32;
            2'b10: depth_of = lcp_pkg::DEPTH_128;
            2'b11: depth_of = lcp_pkg::DEPTH_OFF;
        endcase
    endfunction

    logic [4:0]  ctrl_r;
    logic [1:0]  stat_r;
    logic [1:0]  mask_r;
    logic        los_d_r;
    logic        acc;
    logic        wr;
    logic [31:0] rd_mux;
    // a write lands only at the edge that completes the access
    assign acc = psel && penable;
    assign wr  = acc && pready && pwrite;

    always_ff @(posedge ref_clk_i) begin
        if (regs_rst) begin
            ctrl_r <= lcp_pkg::CTRL_RST;
            mask_r <= lcp_pkg::MASK_RST;
        end else if (wr) begin
            if (paddr == lcp_pkg::OFS_CTRL)
                ctrl_r <= pwdata[4:0];
            if (paddr == lcp_pkg::OFS_MASK)
                mask_r <= pwdata[1:0];
        end
    end

    a_regs_reset: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !rrst_n |=> ctrl_r == lcp_pkg::CTRL_RST &&
                    mask_r == lcp_pkg::MASK_RST && stat_r == 2'h0)
        else $error("register reset ignored");

    // edge tracker ignores the register reset: no false loss edge after it
    logic [1:0] ev;
    assign ev = {!los_s && los_d_r, los_s && !los_d_r};
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i)
            los_d_r <= 1'b0;
        else
            los_d_r <= los_s;
    end

    // set beats write-one-clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (regs_rst)
            stat_r <= '0;
        else if (wr && paddr == lcp_pkg::OFS_STAT)
            stat_r <= (stat_r & ~pwdata[1:0]) | ev;
        else
            stat_r <= stat_r | ev;
    end

    a_stat_set_wins: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (!regs_rst && los_s && !los_d_r)
        |=> stat_r[lcp_pkg::EV_LOS_SET])
        else $error("loss event lost");

    // pending interrupt gated by the enable bit
    logic pend;
    assign pend = |(stat_r & mask_r) && ctrl_r[lcp_pkg::CTRL_INT_EN];

    // effective config: straps in hardware mode, register in host
    logic mute_en, cfg_lo, cfg_hi, cfg_path;
    assign mute_en  = host_s ? ctrl_r[lcp_pkg::CTRL_MUTE] : mute_pin_s;
    assign cfg_lo   = host_s ? ctrl_r[lcp_pkg::CTRL_JA_LO] : ja_lo_s;
    assign cfg_hi   = host_s ? ctrl_r[lcp_pkg::CTRL_JA_HI] : ja_hi_s;
    assign cfg_path = host_s ? ctrl_r[lcp_pkg::CTRL_PATH]  : path_s;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            shared_pin_o    <= 1'b1;
            shared_pin_oe_o <= 1'b0;
            irq_o           <= 1'b0;
        end else begin
            // host mode always drives the pin: low when pending, high otherwise
            shared_pin_oe_o <= host_s;
            shared_pin_o    <= !pend;
            irq_o           <= pend;
        end
    end

    a_pin_low_irq: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (host_s && pend) |=> (shared_pin_oe_o && !shared_pin_o))
        else $error("pending interrupt not driven low");
    a_int_en_off: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !ctrl_r[lcp_pkg::CTRL_INT_EN] |=> shared_pin_o && !irq_o)
        else $error("interrupt shown while disabled");
    a_irq_masked: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (stat_r & mask_r) == 2'h0 |=> !irq_o && shared_pin_o)
        else $error("masked event raised interrupt");
    a_pin_role: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        1'b1 |=> shared_pin_oe_o == $past(host_s))
        else $error("shared pin role wrong");

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            jatt_depth_o   <= lcp_pkg::DEPTH_16;
            jatt_en_o      <= 1'b1;
            jatt_tx_path_o <= 1'b0;
        end else begin
            jatt_depth_o   <= depth_of(cfg_lo, cfg_hi);
            jatt_en_o      <= !(cfg_lo && cfg_hi);
            jatt_tx_path_o <= cfg_path;
        end
    end

    a_depth_off: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (!host_s && ja_lo_s && ja_hi_s) |=> !jatt_en_o)
        else $error("attenuator not disabled");
    a_depth_128: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (!host_s && ja_lo_s && !ja_hi_s)
        |=> jatt_depth_o == lcp_pkg::DEPTH_128)
        else $error("wrong fifo depth");
    a_depth_32: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (!host_s && !ja_lo_s && ja_hi_s)
        |=> jatt_depth_o == lcp_pkg::DEPTH_32 && jatt_en_o)
        else $error("wrong fifo depth");
    a_path_sel: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !host_s |=> jatt_tx_path_o == $past(path_s))
        else $error("path select wrong");

    // data path sees pins directly; mute is a plain gate
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rx_pos_data_o <= 1'b0;
            rx_neg_data_o <= 1'b0;
        end else begin
            rx_pos_data_o <= rx_pos_i && !(mute_en && los_s);
            rx_neg_data_o <= rx_neg_i && !(mute_en && los_s);
        end
    end

    a_mute_los: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (!host_s && mute_pin_s && los_s)
        |=> !rx_pos_data_o && !rx_neg_data_o)
        else $error("data not muted on loss");
    a_no_loss_pass: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !los_s |=> rx_pos_data_o == $past(rx_pos_i) &&
                   rx_neg_data_o == $past(rx_neg_i))
        else $error("data lost without loss");

    // apb: one wait state buys flop-driven bus outputs;
    // unmapped addresses read zero and answer with an error
    logic mapped;
    assign mapped = paddr == lcp_pkg::OFS_CTRL ||
                    paddr == lcp_pkg::OFS_STAT ||
                    paddr == lcp_pkg::OFS_MASK ||
                    paddr == lcp_pkg::OFS_JATT;
    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr)
            lcp_pkg::OFS_CTRL: rd_mux = {27'h0, ctrl_r};
            lcp_pkg::OFS_STAT: rd_mux = {30'h0, stat_r};
            lcp_pkg::OFS_MASK: rd_mux = {30'h0, mask_r};
            lcp_pkg::OFS_JATT: rd_mux = {22'h0, jatt_tx_path_o,
                                         jatt_en_o, jatt_depth_o};
            default:           rd_mux = 32'h0;
        endcase
    end

    // ready is a one-cycle pulse; read data stands with it
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (acc && !pready) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0 : rd_mux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
    end
endmodule

// file: shared/lcp_pkg.sv
// What this block does
// - register reset pin restores all defaults
// - host mode: pending interrupt drives pin low
// - interrupt enable zero suppresses interrupt pin
// - straps pick 16/32/128 fifo or disable
// - path select high transmit, low receive
// - mute enabled and loss forces data low
package lcp_pkg;
    // apb byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_JATT   = 8'h0C;
    // control register fields
    localparam int CTRL_INT_EN   = 0;
    localparam int CTRL_MUTE     = 1;
    localparam int CTRL_JA_LO    = 2;
    localparam int CTRL_JA_HI    = 3;
    localparam int CTRL_PATH     = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // status / mask bits
    localparam int EV_LOS_SET    = 0;
    localparam int EV_LOS_CLR    = 1;
    localparam int EV_W          = 2;
    localparam logic [1:0] MASK_RST = 2'h3;
    // attenuator depth codes
    localparam logic [7:0] DEPTH_16  = 8'h10;
    localparam logic [7:0] DEPTH_32  = 8'h20;
    localparam logic [7:0] DEPTH_128 = 8'h80;
    localparam logic [7:0] DEPTH_OFF = 8'h00;
endpackage

// file: src/lcp_sync2.sv
`timescale 1ns/1ps
module lcp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,   // clock
    input  wire logic         reset_n_i,   // sync reset
    input  wire logic [W-1:0] d_i,         // async level
    output logic      [W-1:0] q_o          // synchronised level
);
    logic [W-1:0] meta_r;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// file: tb/lcp_far_model.sv
`timescale 1ns/1ps
module lcp_far_model (
    input  wire logic       pin_oe_i,   // device drives shared pin
    input  wire logic       pin_val_i,  // device shared pin value
    input  wire logic [3:0] cfg_i,      // {mute,path,lo,hi} straps
    output logic            pin_lvl_o,  // resolved shared pin level
    output logic            lo_o,       // attenuator strap lo
    output logic            hi_o,       // attenuator strap hi
    output logic            path_o      // path strap
);
    // board strap only wins while the device lets go of the pin
    assign pin_lvl_o = pin_oe_i ? pin_val_i : cfg_i[3];
    assign lo_o      = cfg_i[1];
    assign hi_o      = cfg_i[0];
    assign path_o    = cfg_i[2];
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic        clk, rst_n, rrst_n, host, los, rx, err;
    logic        psel, penable, pwrite, pready, pslverr;
    logic        pin_o, pin_oe, pin_l, lo, hi, path;
    logic        rpo, rno, jen, jtx, irq;
    logic [3:0]  cfg;
    logic [7:0]  paddr, depth;
    logic [31:0] pwdata, prdata, q;
    int          num_errors, cmp_count;
    logic [7:0]  dtab [4] = '{lcp_pkg::DEPTH_16, lcp_pkg::DEPTH_32,
                              lcp_pkg::DEPTH_128, lcp_pkg::DEPTH_OFF};

    lcp_far_model far (.pin_oe_i(pin_oe), .pin_val_i(pin_o), .cfg_i(cfg),
        .pin_lvl_o(pin_l), .lo_o(lo), .hi_o(hi), .path_o(path));
    lcp_top dut (.ref_clk_i(clk), .reset_n_i(rst_n), .reg_reset_n_i(rrst_n),
        .host_mode_i(host), .shared_pin_i(pin_l), .shared_pin_o(pin_o),
        .shared_pin_oe_o(pin_oe), .jatt_cfg_lo_i(lo), .jatt_cfg_hi_i(hi),
        .jatt_path_sel_i(path), .los_i(los), .rx_pos_i(rx), .rx_neg_i(rx),
        .rx_pos_data_o(rpo), .rx_neg_data_o(rno), .jatt_depth_o(depth),
        .jatt_en_o(jen), .jatt_tx_path_o(jtx), .irq_o(irq), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            $display("[ERR] %0t no pready", $time);
            print_verdict();
        end
    endtask

    initial begin
        num_errors = 0;
        cmp_count  = 0;
        rst_n      = 1'b0;
        rrst_n     = 1'b1;
        host       = 1'b1;
        los        = 1'b0;
        rx         = 1'b1;
        cfg        = 4'h0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        q          = 32'h0;
        err        = 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(4);
        apb(1'b0, lcp_pkg::OFS_CTRL, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, lcp_pkg::OFS_MASK, 32'h0);
        `CHK(q, 32'h3)
        apb(1'b0, lcp_pkg::OFS_JATT, 32'h0);
        `CHK(q, ({22'h0, 1'b0, 1'b1, lcp_pkg::DEPTH_16}))
        `CHK(({pin_oe, pin_o, irq}), 3'h6)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(({err, q}), ({1'b1, 32'h0}))
        apb(1'b1, lcp_pkg::OFS_CTRL, 32'h1);
        los <= 1'b1;
        cyc(6);
        `CHK(({irq, pin_o}), 2'h2)
        apb(1'b0, lcp_pkg::OFS_STAT, 32'h0);
        `CHK(q, 32'h1)
        apb(1'b1, lcp_pkg::OFS_MASK, 32'h0);
        cyc(2);
        `CHK(({irq, pin_o}), 2'h1)
        apb(1'b1, lcp_pkg::OFS_MASK, 32'h3);
        apb(1'b1, lcp_pkg::OFS_CTRL, 32'h0);
        cyc(2);
        `CHK(({irq, pin_o}), 2'h1)
        apb(1'b1, lcp_pkg::OFS_CTRL, 32'h1);
        cyc(2);
        `CHK(({irq, pin_o}), 2'h2)
        apb(1'b1, lcp_pkg::OFS_STAT, 32'h1);
        cyc(2);
        `CHK(({irq, pin_o}), 2'h1)
        // host mode: register fields pick the attenuator, straps ignored
        cfg <= 4'h7;
        apb(1'b1, lcp_pkg::OFS_CTRL, 32'h15);
        apb(1'b0, lcp_pkg::OFS_JATT, 32'h0);
        `CHK(q, ({22'h0, 1'b1, 1'b1, lcp_pkg::DEPTH_128}))
        `CHK(({jtx, jen, depth}), ({1'b1, 1'b1, lcp_pkg::DEPTH_128}))
        apb(1'b1, lcp_pkg::OFS_MASK, 32'h1);
        los <= 1'b0;
        cyc(6);
        `CHK(({irq, pin_o}), 2'h1)
        apb(1'b0, lcp_pkg::OFS_STAT, 32'h0);
        `CHK(q, 32'h2)
        rrst_n <= 1'b0;
        cyc(4);
        rrst_n <= 1'b1;
        cyc(4);
        apb(1'b0, lcp_pkg::OFS_CTRL, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, lcp_pkg::OFS_MASK, 32'h0);
        `CHK(q, 32'h3)
        apb(1'b0, lcp_pkg::OFS_STAT, 32'h0);
        `CHK(q, 32'h0)
        apb(1'b0, lcp_pkg::OFS_JATT, 32'h0);
        `CHK(q, ({22'h0, 1'b0, 1'b1, lcp_pkg::DEPTH_16}))
        // los stays high so the mute check below sees a declared loss
        los  <= 1'b1;
        host <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cfg <= i[3:0];
            cyc(5);
            `CHK(depth, dtab[i[1:0]])
            `CHK(jen, (i[1:0] != 2'h3))
            `CHK(jtx, i[2])
        end
        `CHK(pin_oe, 1'b0)
        cfg <= 4'h8;
        cyc(5);
        `CHK(({rpo, rno}), 2'h0)
        los <= 1'b0;
        cyc(5);
        `CHK(({rpo, rno}), 2'h3)
        cfg <= 4'h0;
        los <= 1'b1;
        cyc(5);
        `CHK(({rpo, rno}), 2'h3)
        print_verdict();
    end
endmodule
